// ==== ust_pkg.sv ====
// Constants for the synchronous-slave transmit block: register map, fields, reset values.
// Assumes a 32-bit classic Wishbone slave port with byte addresses on adr_i.

package ust_pkg;
   // Register byte addresses
   localparam logic [7:0] OFS_TX_STATUS = 8'h00;
   localparam logic [7:0] OFS_RX_STATUS = 8'h04;
   localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
   localparam logic [7:0] OFS_TX_HOLD   = 8'h0C;
   localparam logic [7:0] OFS_PER_FLAGS = 8'h10;
   localparam logic [7:0] OFS_PER_ENAB  = 8'h14;
   localparam logic [7:0] OFS_INT_CTRL  = 8'h18;

   // Transmit status and control fields
   localparam int TXS_CLOCK_SOURCE = 7;
   localparam int TXS_NINE_BIT     = 6;
   localparam int TXS_TX_ENABLE    = 5;
   localparam int TXS_SYNC         = 4;
   localparam int TXS_SHIFT_EMPTY  = 1;
   localparam int TXS_NINTH_VALUE  = 0;
   // Receive status and control fields
   localparam int RXS_PORT_ENABLE  = 7;
   // Baud control fields
   localparam int BDC_DATA_INVERT  = 5;
   localparam int BDC_CLOCK_INVERT = 4;
   // Peripheral flag and enable position of the transmit event
   localparam int PER_TX_BIT       = 4;
   // Interrupt control fields
   localparam int INT_GLOBAL       = 7;
   localparam int INT_PERIPH       = 6;

   // Reset values
   localparam logic [7:0] RST_TX_STATUS = 8'h00;
   localparam logic [7:0] RST_RX_STATUS = 8'h00;
   localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
   localparam logic [7:0] RST_PER_ENAB  = 8'h00;
   localparam logic [7:0] RST_INT_CTRL  = 8'h00;

   // Word lengths
   localparam logic [3:0] BITS_SHORT = 4'h8;
   localparam logic [3:0] BITS_LONG  = 4'h9;
endpackage

// ==== ust_edge_if.sv ====
// Interface between the shift clock sampler and the transmit core.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface ust_edge_if;
   logic invert;      // Clock polarity select, from core
   logic active_edge; // One-cycle pulse per shift clock cycle
   modport sampler (input invert, output active_edge);
   modport core    (output invert, input active_edge);
endinterface // ust_edge_if

// ==== ust_clk_sampler.sv ====
// Samples the external shift clock pin and marks each active edge.
// Assumes the pin is asynchronous to clk_i and much slower than it.
`timescale 1ns/1ps
module ust_clk_sampler (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Pin
   input  wire logic shift_clock_pin_i,
   // Core side
   ust_edge_if.sampler edge_if
);
   logic sync1_reg;
   logic sync2_reg;
   logic level_prev_reg;
   logic level;

   // Polarity applied after the synchroniser
   assign level = sync2_reg ^ edge_if.invert;

   // Two-stage synchroniser, then previous level for edge finding
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg      <= 1'b0;
         sync2_reg      <= 1'b0;
         level_prev_reg <= 1'b0;
      end else begin
         sync1_reg      <= shift_clock_pin_i;
         sync2_reg      <= sync1_reg;
         level_prev_reg <= level;
      end
   end

   // Rising edge of the polarity-corrected clock advances the shifter
   assign edge_if.active_edge = level & ~level_prev_reg;

   edge_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_if.active_edge |=> !edge_if.active_edge)
      else $error("active edge lasted more than one cycle");
endmodule // ust_clk_sampler

// ==== ust_tx_core.sv ====
// Synchronous-slave transmitter: Wishbone registers, holding register, shift register.
// Assumes the far master drives the shift clock and a Wishbone master drives the bus.
`timescale 1ns/1ps
module ust_tx_core (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Core power state
   input  wire logic        sleep_i,
   output logic             wake_o,
   output logic             irq_vector_o,
   // Pins
   input  wire logic        shift_clock_pin_i,
   input  wire logic        serial_data_pin_i,
   output logic             serial_data_pin_o,
   output logic             serial_data_pin_oe_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Shift clock sampling
   ust_edge_if edge_if ();

   ust_clk_sampler u_sampler (
      .clk_i             (clk_i),
      .rst_i             (rst_i),
      .shift_clock_pin_i (shift_clock_pin_i),
      .edge_if           (edge_if)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] tx_status_reg;
   logic [7:0] rx_status_reg;
   logic [7:0] baud_ctrl_reg;
   logic [7:0] per_enab_reg;
   logic [7:0] int_ctrl_reg;
   logic [8:0] hold_reg;
   logic       hold_full_reg;
   logic [8:0] shift_reg;
   logic [3:0] bits_left_reg;
   logic       busy_reg;
   logic       ack_reg;
   logic [31:0] rdata_reg;
   logic       data_out_reg;
   logic       data_oe_reg;
   logic       wake_reg;
   logic       vector_reg;

   // Data pin input is not used while transmitting
   logic       unused_data_in;
   assign unused_data_in = serial_data_pin_i;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      hit = (adr == ofs);
   endfunction

   wire bus_req   = cyc_i & stb_i & ~ack_reg;
   // Writes commit at the edge where the master samples ack, while the request still stands
   wire bus_wr    = cyc_i & stb_i & ack_reg & we_i;
   wire wr_lane0  = bus_wr & sel_i[0];
   wire wr_txs    = wr_lane0 & hit(adr_i, ust_pkg::OFS_TX_STATUS);
   wire wr_rxs    = wr_lane0 & hit(adr_i, ust_pkg::OFS_RX_STATUS);
   wire wr_baud   = wr_lane0 & hit(adr_i, ust_pkg::OFS_BAUD_CTRL);
   wire wr_hold   = wr_lane0 & hit(adr_i, ust_pkg::OFS_TX_HOLD);
   wire wr_pen    = wr_lane0 & hit(adr_i, ust_pkg::OFS_PER_ENAB);
   wire wr_int    = wr_lane0 & hit(adr_i, ust_pkg::OFS_INT_CTRL);

   ////////////////////////////////////////////////////////////////////////////
   // Mode and control decode
   wire slave_mode  = ~tx_status_reg[ust_pkg::TXS_CLOCK_SOURCE];
   wire sync_mode   = tx_status_reg[ust_pkg::TXS_SYNC];
   wire port_on     = rx_status_reg[ust_pkg::RXS_PORT_ENABLE];
   wire tx_enable   = tx_status_reg[ust_pkg::TXS_TX_ENABLE];
   wire nine_bit    = tx_status_reg[ust_pkg::TXS_NINE_BIT];
   wire ninth_value = tx_status_reg[ust_pkg::TXS_NINTH_VALUE];
   wire data_invert = baud_ctrl_reg[ust_pkg::BDC_DATA_INVERT];
   // Sleep is deliberately absent: the external clock keeps the shifter going
   wire tx_run      = slave_mode & sync_mode & port_on & tx_enable;
   assign edge_if.invert = baud_ctrl_reg[ust_pkg::BDC_CLOCK_INVERT];

   ////////////////////////////////////////////////////////////////////////////
   // Transfer decision
   wire shift_edge = tx_run & busy_reg & edge_if.active_edge;
   wire last_edge  = shift_edge & (bits_left_reg == 4'h1);
   // Holding word moves at once when the shifter is idle or just finished
   wire xfer       = tx_run & hold_full_reg & (~busy_reg | last_edge);
   wire [3:0] word_bits = nine_bit ? ust_pkg::BITS_LONG : ust_pkg::BITS_SHORT;

   // Holding register occupancy; a write in the transfer cycle refills it
   wire hold_full_next = wr_hold ? 1'b1 : (xfer ? 1'b0 : hold_full_reg);

   // Flag reads set whenever the holding register is empty
   wire tx_flag   = ~hold_full_reg;
   wire tx_irq_en = per_enab_reg[ust_pkg::PER_TX_BIT];
   wire glob_en   = int_ctrl_reg[ust_pkg::INT_GLOBAL] & int_ctrl_reg[ust_pkg::INT_PERIPH];

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   wire [7:0] txs_view = {tx_status_reg[7:2], ~busy_reg, tx_status_reg[0]};
   wire [7:0] flags_view = 8'(tx_flag) << ust_pkg::PER_TX_BIT;
   wire [7:0] rd_byte =
      hit(adr_i, ust_pkg::OFS_TX_STATUS) ? txs_view        :
      hit(adr_i, ust_pkg::OFS_RX_STATUS) ? rx_status_reg   :
      hit(adr_i, ust_pkg::OFS_BAUD_CTRL) ? baud_ctrl_reg   :
      hit(adr_i, ust_pkg::OFS_TX_HOLD)   ? hold_reg[7:0]   :
      hit(adr_i, ust_pkg::OFS_PER_FLAGS) ? flags_view      :
      hit(adr_i, ust_pkg::OFS_PER_ENAB)  ? per_enab_reg    :
      hit(adr_i, ust_pkg::OFS_INT_CTRL)  ? int_ctrl_reg    : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait state, unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg   <= bus_req;
         rdata_reg <= {24'h00_0000, rd_byte};
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; shift-empty bit is hardware state, not stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_status_reg <= ust_pkg::RST_TX_STATUS;
         rx_status_reg <= ust_pkg::RST_RX_STATUS;
         baud_ctrl_reg <= ust_pkg::RST_BAUD_CTRL;
         per_enab_reg  <= ust_pkg::RST_PER_ENAB;
         int_ctrl_reg  <= ust_pkg::RST_INT_CTRL;
      end else begin
         if (wr_txs)  tx_status_reg <= {dat_i[7:2], 1'b0, dat_i[0]};
         if (wr_rxs)  rx_status_reg <= dat_i[7:0];
         if (wr_baud) baud_ctrl_reg <= dat_i[7:0];
         if (wr_pen)  per_enab_reg  <= dat_i[7:0];
         if (wr_int)  int_ctrl_reg  <= dat_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Holding register; ninth bit captured with the word at write time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_reg      <= 9'h000;
         hold_full_reg <= 1'b0;
      end else begin
         if (wr_hold) hold_reg <= {ninth_value, dat_i[7:0]};
         hold_full_reg <= hold_full_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift register: LSB presented at load, one bit per active edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_reg     <= 9'h1FF;
         bits_left_reg <= 4'h0;
         busy_reg      <= 1'b0;
      end else if (!tx_run) begin
         // Dropping any enable abandons the word in flight
         busy_reg      <= 1'b0;
         bits_left_reg <= 4'h0;
      end else if (xfer) begin
         shift_reg     <= hold_reg;
         bits_left_reg <= word_bits;
         busy_reg      <= 1'b1;
      end else if (last_edge) begin
         busy_reg      <= 1'b0;
         bits_left_reg <= 4'h0;
      end else if (shift_edge) begin
         shift_reg     <= {1'b1, shift_reg[8:1]};
         bits_left_reg <= bits_left_reg - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data pin: idle high, polarity applied at the pin
   wire pin_bit = busy_reg ? shift_reg[0] : 1'b1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_out_reg <= 1'b1;
         data_oe_reg  <= 1'b0;
      end else begin
         data_out_reg <= pin_bit ^ data_invert;
         data_oe_reg  <= tx_run;
      end
   end

   assign serial_data_pin_o    = data_out_reg;
   assign serial_data_pin_oe_o = data_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Wake and vector requests to the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_reg   <= 1'b0;
         vector_reg <= 1'b0;
      end else begin
         wake_reg   <= tx_flag & tx_irq_en;
         vector_reg <= tx_flag & tx_irq_en & glob_en;
      end
   end

   assign wake_o       = wake_reg;
   assign irq_vector_o = vector_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   master_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_status_reg[ust_pkg::TXS_CLOCK_SOURCE] |=> !busy_reg)
      else $error("shifter active with clock source select set");

   load_at_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_run && hold_full_reg && !busy_reg && !wr_hold) |=> busy_reg && !hold_full_reg)
      else $error("idle shifter did not take the held word");

   // Watches the read data itself; it was captured one cycle before ack is seen
   flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_o && adr_i == ust_pkg::OFS_PER_FLAGS && $past(hold_full_reg))
         |-> !dat_o[ust_pkg::PER_TX_BIT])
      else $error("transmit flag read as set while holding register full");

   reload_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (last_edge && hold_full_reg && !wr_hold) |=> busy_reg && tx_flag
         && bits_left_reg == word_bits)
      else $error("held word not moved after last bit");

   wake_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_flag && tx_irq_en) ##1 (tx_flag && tx_irq_en) |-> wake_o)
      else $error("flag with enable did not wake");

   sleep_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (sleep_i && shift_edge && !last_edge) |=> bits_left_reg == $past(bits_left_reg) - 4'h1)
      else $error("shifting stalled in sleep");

   // Polarity must hold across the registered pin stage, or a write would trip it
   idle_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!busy_reg ##1 $stable(data_invert)) |-> serial_data_pin_o == !data_invert)
      else $error("idle data pin level wrong for polarity");

   nine_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (xfer && nine_bit) |=> bits_left_reg == 4'h9)
      else $error("nine-bit word loaded with wrong length");

   start_on_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_run && !busy_reg && !hold_full_reg && wr_hold) |=> ##1 busy_reg)
      else $error("write to holding register did not start transmission");

   lsb_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (shift_edge && !last_edge && !xfer) |=> shift_reg[0] == $past(shift_reg[1]))
      else $error("shift order is not LSB first");
endmodule // ust_tx_core

// ==== ust_sync_master_model.sv ====
// Behavioural far-side synchronous master: makes the shift clock and captures the data pin.
// Assumes one frame at a time, started by the bench, with polarities changed only while idle.
`timescale 1ns/1ps
module ust_sync_master_model (
   // Control from the bench
   input  wire logic       start_i,
   input  wire logic [3:0] bits_i,
   input  wire logic       clock_invert_i,
   input  wire logic       data_invert_i,
   // Pins
   input  wire logic       data_pin_i,
   output logic            shift_clock_pin_o,
   // Result
   output logic [8:0]      word_o,
   output logic            done_o
);
   logic clk_level;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock stands still low between frames, as seen through the polarity setting
   assign shift_clock_pin_o = clk_level ^ clock_invert_i;

   initial begin
      clk_level = 1'b0;
      word_o    = 9'h000;
      done_o    = 1'b1;
   end

   // One frame at 64 ns a bit; data taken late in the low phase, well after the shift
   always @(posedge start_i) begin
      done_o = 1'b0;
      word_o = 9'h000;
      #7;
      for (int k = 0; k < int'(bits_i); k++) begin
         #24;
         word_o[k] = data_pin_i ^ data_invert_i;
         #1;
         clk_level = 1'b1;
         #32;
         clk_level = 1'b0;
         #7;
      end
      done_o = 1'b1;
   end
endmodule // ust_sync_master_model

// ==== tb_usart_sync_slave_transmit.sv ====
// Self-checking bench for the synchronous-slave transmitter over classic Wishbone.
// Assumes the far-side master model and the register map of the package.
`timescale 1ns/1ps
module tb_usart_sync_slave_transmit;
   localparam logic [7:0] TX_RUN = (8'h01 << ust_pkg::TXS_TX_ENABLE) | (8'h01 << ust_pkg::TXS_SYNC);
   localparam logic [7:0] EMPTY  = 8'h01 << ust_pkg::TXS_SHIFT_EMPTY;
   localparam logic [7:0] NINE   = 8'h01 << ust_pkg::TXS_NINE_BIT;
   localparam logic [7:0] CSEL   = 8'h01 << ust_pkg::TXS_CLOCK_SOURCE;
   localparam logic [7:0] FLAG   = 8'h01 << ust_pkg::PER_TX_BIT;
   localparam logic [7:0] PORT   = 8'h01 << ust_pkg::RXS_PORT_ENABLE;
   logic        clk, rst, cyc, stb, we, ack, sleep, wake, irq_vec;
   logic        sck, din, dout, doe, start, cinv, dinv, done;
   logic [7:0]  adr, q;
   logic [3:0]  sel, bits;
   logic [31:0] dat_w, dat_r;
   logic [8:0]  word;
   int          error_cnt, check_count, cycles;

   ////////////////////////////////////////////////////////////////////////////////
   ust_tx_core i_ust_tx_core (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .sleep_i(sleep),
      .wake_o(wake), .irq_vector_o(irq_vec), .shift_clock_pin_i(sck), .serial_data_pin_i(din),
      .serial_data_pin_o(dout), .serial_data_pin_oe_o(doe));
   ust_sync_master_model i_ust_sync_master_model (.start_i(start), .bits_i(bits),
      .clock_invert_i(cinv), .data_invert_i(dinv), .data_pin_i(din),
      .shift_clock_pin_o(sck), .word_o(word), .done_o(done));
   // A released data line shows the inverse, so a stale copy is never mistaken for data
   assign din = doe ? dout : ~dout;

   always #4 clk = ~clk;
   // Hang guard: far more than the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         error_cnt++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      check({15'h0, seen}, {15'h0, exp});
   endtask
   // One classic cycle; request held until ack is sampled high, then one idle cycle
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= {24'h000000, d};
      // No local limit: only the hang guard ends a wait for ack
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      wb(a, 1'b0, 8'h00);
      check({8'h00, q}, {8'h00, exp});
   endtask
   // Let the far master clock one frame and compare the captured word
   task automatic frame(input logic [3:0] n, input logic [8:0] exp);
      int t;
      t = 0;
      bits  <= n;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      do begin
         @(posedge clk);
         t++;
      end while (done !== 1'b1 && t < 300);
      if (t >= 300) error_cnt++;
      check({7'h00, word}, {7'h00, exp});
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {clk, cyc, stb, we, sleep, start, cinv, dinv} = 8'h00;
      {rst, sel, bits, adr, dat_w} = {1'b1, 4'hF, 4'h8, 8'h00, 32'h00000000};
      {error_cnt, check_count, cycles} = {32'd0, 32'd0, 32'd0};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, unmapped place and the read-only flag register
      rd(ust_pkg::OFS_TX_STATUS, ust_pkg::RST_TX_STATUS | EMPTY);
      rd(ust_pkg::OFS_RX_STATUS, ust_pkg::RST_RX_STATUS);
      rd(ust_pkg::OFS_BAUD_CTRL, ust_pkg::RST_BAUD_CTRL);
      rd(ust_pkg::OFS_PER_ENAB, ust_pkg::RST_PER_ENAB);
      rd(ust_pkg::OFS_INT_CTRL, ust_pkg::RST_INT_CTRL);
      wr(ust_pkg::OFS_PER_FLAGS, 8'h00);
      rd(ust_pkg::OFS_PER_FLAGS, FLAG);
      wr(8'h1C, 8'hFF);
      rd(8'h1C, 8'h00);
      // Port set up with both receive enables clear, interrupts wanted
      wr(ust_pkg::OFS_RX_STATUS, PORT);
      wr(ust_pkg::OFS_TX_STATUS, TX_RUN);
      wr(ust_pkg::OFS_PER_ENAB, FLAG);
      wr(ust_pkg::OFS_INT_CTRL, 8'hC0);
      chk1(wake, 1'b1);
      // Asleep, then two words written: shifting goes on, flag waits for the held word
      sleep <= 1'b1;
      wr(ust_pkg::OFS_TX_HOLD, 8'hA5);
      wr(ust_pkg::OFS_TX_HOLD, 8'h3C);
      repeat (2) @(posedge clk);
      rd(ust_pkg::OFS_PER_FLAGS, 8'h00);
      chk1(wake, 1'b0);
      chk1(doe, 1'b1);
      frame(4'h8, 9'h0A5);
      repeat (6) @(posedge clk);
      rd(ust_pkg::OFS_PER_FLAGS, FLAG);
      chk1(doe, 1'b1);
      chk1(wake, 1'b1);
      chk1(irq_vec, 1'b1);
      frame(4'h8, 9'h03C);
      repeat (6) @(posedge clk);
      rd(ust_pkg::OFS_TX_STATUS, TX_RUN | EMPTY);
      chk1(doe, 1'b1);
      chk1(dout, 1'b1);
      wr(ust_pkg::OFS_INT_CTRL, 8'h40);
      repeat (3) @(posedge clk);
      chk1(irq_vec, 1'b0);
      chk1(wake, 1'b1);
      sleep <= 1'b0;
      // Both polarities inverted
      wr(ust_pkg::OFS_BAUD_CTRL, 8'h30);
      cinv <= 1'b1;
      dinv <= 1'b1;
      repeat (4) @(posedge clk);
      chk1(dout, 1'b0);
      wr(ust_pkg::OFS_TX_HOLD, 8'h5A);
      frame(4'h8, 9'h05A);
      // Nine-bit word, ninth bit loaded before the word
      wr(ust_pkg::OFS_TX_STATUS, TX_RUN | NINE | 8'h01);
      wr(ust_pkg::OFS_TX_HOLD, 8'h96);
      frame(4'h9, 9'h196);
      // Clock source select set: nothing shifts, word stays held until slave mode returns
      wr(ust_pkg::OFS_TX_STATUS, TX_RUN | CSEL);
      wr(ust_pkg::OFS_TX_HOLD, 8'h11);
      frame(4'h8, 9'h000);
      chk1(doe, 1'b0);
      rd(ust_pkg::OFS_PER_FLAGS, 8'h00);
      wr(ust_pkg::OFS_TX_STATUS, TX_RUN);
      repeat (4) @(posedge clk);
      frame(4'h8, 9'h011);
      // A write without the low byte lane is ignored
      sel <= 4'hE;
      wr(ust_pkg::OFS_PER_ENAB, 8'h00);
      sel <= 4'hF;
      rd(ust_pkg::OFS_PER_ENAB, FLAG);
      print_verdict();
   end
endmodule // tb_usart_sync_slave_transmit
